/* dep_cfg.svh */
// Constants for the dual-edge pad I/O logic block
`ifndef DEP_CFG_SVH
`define DEP_CFG_SVH
`define DEP_ADR_CTRL 2'h0
`define DEP_ADR_STAT 2'h1
`define DEP_CTRL_RST 10'h000
`define DEP_CTRL_W 10
`define DEP_FIFO_DEPTH 4
`define DEP_WORD_W 3
`define DEP_DATA_W 32
`endif

/* dep_pkg.sv */
// Types shared by the pad I/O logic block
package dep_pkg;
  // Software control word, one field per option
  typedef struct packed {
    logic launch_hold;
    logic resync;
    logic dual_edge;
    logic out_inv;
    logic oe_neg;
    logic out_neg;
    logic in_neg;
    logic oe_reg;
    logic out_reg;
    logic in_reg;
  } dep_ctrl_t;

  // One launch word from the core fabric
  typedef struct packed {
    logic drive_en;
    logic [1:0] data;
  } dep_word_t;

  // Classic Wishbone request from the master
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [3:0] adr;
    logic [31:0] dat;
  } dep_wb_req_t;
endpackage

/* dep_pad_io.sv */
// Dual-edge pad I/O logic with Wishbone control and launch FIFO
`timescale 1ns/1ps
`include "dep_cfg.svh"

module dep_fifo #(
  parameter int WIDTH = `DEP_WORD_W,
  parameter int DEPTH = `DEP_FIFO_DEPTH
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o,
  output logic [$clog2(DEPTH):0] level_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_reg, wr_next, rd_reg, rd_next;
  logic [AW:0] cnt_reg, cnt_next;
  logic push, pop;

  // Pointer and count update
  always_comb begin
    push = in_valid_i && (cnt_reg != (AW+1)'(DEPTH));
    pop = out_ready_i && (cnt_reg != '0);
    wr_next = push ? ((wr_reg == AW'(DEPTH - 1)) ? '0 : wr_reg + 1'b1)
                   : wr_reg;
    rd_next = pop ? ((rd_reg == AW'(DEPTH - 1)) ? '0 : rd_reg + 1'b1)
                  : rd_reg;
    cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end else begin
      wr_reg <= wr_next;
      rd_reg <= rd_next;
      cnt_reg <= cnt_next;
    end
  end

  // Storage array, no reset needed
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_reg[wr_reg] <= in_data_i;
    end
  end

  assign in_ready_o = (cnt_reg != (AW+1)'(DEPTH));
  assign out_valid_o = (cnt_reg != '0);
  assign out_data_o = mem_reg[rd_reg];
  assign level_o = cnt_reg;
endmodule

// Functional notes
// R1 - Capture bit 0 normally; dual-edge gives rising sample bit 0, falling bit 1.
// R2 - Drive pad from launch bit 0; dual-edge sends bit 0 high, bit 1 low half.
// R3 - Without input register, an unregistered bypass route feeds clock nets.
// R4 - Drive enable from the core, optionally registered before the driver.
// R5 - Output and drive-enable registers run on the launch clock.
// R6 - Input capture registers run on the capture clock.
// R7 - Dual-edge mode moves a two-bit word per cycle on both edges.
// R8 - Normal dual-edge timing hands each bit over on its own edge.
// R9 - Resync dual-edge timing aligns both bits to the rising edge.
// R10 - Resync input delays the falling sample by half a cycle.
// R11 - Pins without dual-edge capability never do dual-edge transfer.
// R12 - Each register picks rising or falling edge; paths registered apart.
// R13 - Output register value can be inverted before the pad.
// R14 - Bypass route is purely combinational, never registered.
// R15 - Pad driven only with drive enable; capture keeps sampling the pad.
// R16 - Core gives stable launch data early and samples capture after edge.
module dep_pad_io
  import dep_pkg::*;
#(
  parameter bit DUAL_EDGE_CAPABLE = 1'b1,
  parameter int FIFO_DEPTH = `DEP_FIFO_DEPTH
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire dep_pkg::dep_wb_req_t wb_req_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire dep_pkg::dep_word_t launch_word_i,
  input wire logic launch_valid_i,
  output logic launch_ready_o,
  output logic [1:0] capture_o,
  output logic bypass_route_o,
  input wire logic pad_i,
  output logic pad_o,
  output logic pad_oe_o
);
  import dep_pkg::*;

  logic rst_s1_reg, rst_n;
  dep_ctrl_t ctrl_reg, ctrl_next;
  logic ack_reg, ack_next;
  logic [31:0] rdat_reg, rdat_next;
  dep_word_t cur_reg, cur_next, fifo_word;
  logic fifo_valid, fifo_pop, dual;
  logic [$clog2(FIFO_DEPTH):0] level;
  logic in_p_reg, in_n_reg, in_rs_reg;
  logic dp_reg, dp_next, dn_reg, dn_next, hold_reg;
  logic op_reg, on_reg, ep_reg, en_reg;
  logic out_sdr, oe_sel;
  logic wb_hit;

  // Reset release through two flops
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_s1_reg <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_n <= rst_s1_reg;
    end
  end

  // R11 dual-edge gating
  assign dual = ctrl_reg.dual_edge && DUAL_EDGE_CAPABLE;

  // Wishbone slave: one-cycle ack, unmapped reads zero
  always_comb begin
    wb_hit = wb_req_i.cyc && wb_req_i.stb && !ack_reg;
    ack_next = wb_hit;
    ctrl_next = ctrl_reg;
    rdat_next = rdat_reg;
    if (wb_hit && wb_req_i.we && wb_req_i.sel[0] &&
        wb_req_i.adr[3:2] == `DEP_ADR_CTRL) begin
      ctrl_next = dep_ctrl_t'(wb_req_i.dat[`DEP_CTRL_W-1:0]);
    end
    if (wb_hit) begin
      unique case (wb_req_i.adr[3:2])
        `DEP_ADR_CTRL: rdat_next = 32'(ctrl_reg);
        `DEP_ADR_STAT: rdat_next = 32'({level, cur_reg, capture_o, pad_i});
        default: rdat_next = 32'h0;
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= `DEP_CTRL_RST;
      ack_reg <= 1'b0;
      rdat_reg <= 32'h0;
    end else begin
      ctrl_reg <= ctrl_next;
      ack_reg <= ack_next;
      rdat_reg <= rdat_next;
    end
  end
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdat_reg;

  // Launch words queue up; hold bit stalls the drain
  dep_fifo #(.WIDTH(`DEP_WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_i(mclk_i),
    .rst_n_i(rst_n),
    .in_valid_i(launch_valid_i),
    .in_ready_o(launch_ready_o),
    .in_data_i(launch_word_i),
    .out_valid_o(fifo_valid),
    .out_ready_i(fifo_pop),
    .out_data_o(fifo_word),
    .level_o(level)
  );

  // Current launch word, taken on the launch clock
  always_comb begin
    fifo_pop = fifo_valid && !ctrl_reg.launch_hold;
    cur_next = fifo_pop ? fifo_word : cur_reg;
  end

  // R5 launch-clock rising registers
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      cur_reg <= '0;
      dp_reg <= 1'b0;
      op_reg <= 1'b0;
      ep_reg <= 1'b0;
      hold_reg <= 1'b0;
    end else begin
      cur_reg <= cur_next;
      dp_reg <= dp_next;
      op_reg <= cur_reg.data[0];
      ep_reg <= cur_reg.drive_en;
      hold_reg <= cur_reg.data[1];
    end
  end

  // R12 launch-clock falling registers
  always_ff @(negedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      dn_reg <= 1'b0;
      on_reg <= 1'b0;
      en_reg <= 1'b0;
    end else begin
      dn_reg <= dn_next;
      on_reg <= cur_reg.data[0];
      en_reg <= cur_reg.drive_en;
    end
  end

  // R2 R7 dual-edge launch: xor pair yields bit 0 high, bit 1 low half
  // R8 R9 normal takes bit 1 at the fall, resync from rising-edge copy
  always_comb begin
    dp_next = cur_reg.data[0] ^ dn_reg;
    dn_next = (ctrl_reg.resync ? hold_reg : cur_reg.data[1]) ^ dp_reg;
  end

  // R12 R13 dual-edge or single-rate output select and inversion
  always_comb begin
    if (dual) begin
      out_sdr = dp_reg ^ dn_reg;
    end else if (ctrl_reg.out_reg) begin
      out_sdr = ctrl_reg.out_neg ? on_reg : op_reg;
    end else begin
      out_sdr = cur_reg.data[0];
    end
    pad_o = out_sdr ^ ctrl_reg.out_inv;
  end

  // R4 R15 drive enable, registered or direct
  always_comb begin
    if (ctrl_reg.oe_reg) begin
      oe_sel = ctrl_reg.oe_neg ? en_reg : ep_reg;
    end else begin
      oe_sel = cur_reg.drive_en;
    end
    pad_oe_o = oe_sel;
  end

  // R6 capture-clock rising samples and resync stage
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      in_p_reg <= 1'b0;
      in_rs_reg <= 1'b0;
    end else begin
      in_p_reg <= pad_i;
      // R10 falling sample moved half a cycle
      in_rs_reg <= in_n_reg;
    end
  end

  // R6 capture-clock falling sample
  always_ff @(negedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      in_n_reg <= 1'b0;
    end else begin
      in_n_reg <= pad_i;
    end
  end

  // R1 capture bus select
  always_comb begin
    if (dual) begin
      capture_o = {ctrl_reg.resync ? in_rs_reg : in_n_reg, in_p_reg};
    end else if (ctrl_reg.in_reg) begin
      capture_o = {1'b0, ctrl_reg.in_neg ? in_n_reg : in_p_reg};
    end else begin
      capture_o = {1'b0, pad_i};
    end
  end

  // R3 R14 bypass route, combinational
  assign bypass_route_o = ctrl_reg.in_reg ? 1'b0 : pad_i;

  // Bus answer, pad path and launch FIFO checks
  a_ack_one_cycle: assert property (@(posedge mclk_i) disable iff (!rst_n)
    wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
  a_ack_after_req: assert property (@(posedge mclk_i) disable iff (!rst_n)
    (wb_req_i.cyc && wb_req_i.stb && !wb_ack_o) |=> wb_ack_o)
    else $error("ack missing");
  a_rise_capture: assert property (@(posedge mclk_i) disable iff (!rst_n) // R1
    (ctrl_reg.in_reg && !ctrl_reg.in_neg && !dual) ##1 $stable(ctrl_reg)
    |-> capture_o == {1'b0, $past(pad_i)}) else $error("bad capture");
  a_resync_fall: assert property (@(posedge mclk_i) disable iff (!rst_n) // R10
    (dual && ctrl_reg.resync) ##1 $stable(ctrl_reg)
    |-> capture_o[1] == $past(in_n_reg)) else $error("bad resync bit");
  a_bypass_comb: assert property (@(posedge mclk_i) disable iff (!rst_n) // R14
    !ctrl_reg.in_reg |-> bypass_route_o == pad_i)
    else $error("bypass not direct");
  a_no_dual_cap: assert property (@(posedge mclk_i) disable iff (!rst_n) // R11
    !dual |-> capture_o[1] == 1'b0)
    else $error("dual edge on plain pin");
  a_sdr_launch: assert property (@(posedge mclk_i) disable iff (!rst_n) // R13
    (ctrl_reg.out_reg && !ctrl_reg.out_neg && !dual) ##1 $stable(ctrl_reg)
    |-> pad_o == ($past(cur_reg.data[0]) ^ ctrl_reg.out_inv))
    else $error("bad launch");
  a_oe_reg_path: assert property (@(posedge mclk_i) disable iff (!rst_n) // R4
    (ctrl_reg.oe_reg && !ctrl_reg.oe_neg) ##1 $stable(ctrl_reg)
    |-> pad_oe_o == $past(cur_reg.drive_en)) else $error("bad drive enable");
  a_dual_fall: assert property (@(posedge mclk_i) disable iff (!rst_n) // R2
    (dual && !ctrl_reg.resync) |-> pad_o == (cur_reg.data[1] ^
    ctrl_reg.out_inv)) else $error("dual launch mismatch");
  a_resync_out: assert property (@(posedge mclk_i) disable iff (!rst_n) // R9
    (dual && ctrl_reg.resync) |-> pad_o == ($past(cur_reg.data[1]) ^
    ctrl_reg.out_inv)) else $error("resync launch mismatch");
  a_fifo_full_stall: assert property (@(posedge mclk_i) disable iff (!rst_n)
    (level == ($bits(level))'(FIFO_DEPTH)) |-> !launch_ready_o)
    else $error("ready while full");
  a_full_hold: assert property (@(posedge mclk_i) disable iff (!rst_n)
    (!launch_ready_o && !fifo_pop) |=> level == $past(level))
    else $error("push taken while full");
endmodule

/* dep_pad_peer.sv */
// Far-side device model for the pad line
`timescale 1ns/1ps
module dep_pad_peer (
  input wire logic clk_i,
  input wire logic pad_o_i,
  input wire logic pad_oe_i,
  input wire logic rise_val_i,
  input wire logic fall_val_i,
  output logic pad_i_o
);
  logic ext;
  // Falling-edge value set after rising, rising value after falling
  initial ext = 1'b1;
  always @(posedge clk_i) begin
    #6 ext = fall_val_i;
  end
  always @(negedge clk_i) begin
    #6 ext = rise_val_i;
  end
  // drive only while the block releases
  assign pad_i_o = pad_oe_i ? pad_o_i : ext;
endmodule

/* dual_edge_pad_io_logic_bench.sv */
// Self-checking bench for the dual-edge pad logic
`timescale 1ns/1ps
module dual_edge_pad_io_logic_bench;
  import dep_pkg::*;
  logic mclk_i, rst_n_i, wb_ack, lv, lr, byp, pad_i, pad_o, pad_oe;
  logic rv, fv;
  logic [1:0] cap;
  logic [31:0] wb_dat, q;
  dep_wb_req_t req;
  dep_word_t lw;
  int fail_count = 0;
  int n_tests = 0;
  int n;
  // Device and its far-side partner
  dep_pad_io dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .wb_req_i(req),
    .wb_dat_o(wb_dat), .wb_ack_o(wb_ack), .launch_word_i(lw),
    .launch_valid_i(lv), .launch_ready_o(lr), .capture_o(cap),
    .bypass_route_o(byp), .pad_i(pad_i), .pad_o(pad_o),
    .pad_oe_o(pad_oe));
  dep_pad_peer peer (.clk_i(mclk_i), .pad_o_i(pad_o), .pad_oe_i(pad_oe),
    .rise_val_i(rv), .fall_val_i(fv), .pad_i_o(pad_i));
  task automatic finish_test;
    $display("Checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One classic Wishbone cycle, held until ack
  task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d);
    int i;
    req <= '{1'b1, 1'b1, we, 4'hf, a, d};
    i = 0;
    do begin
      @(posedge mclk_i);
      i++;
    end while (wb_ack !== 1'b1);
    chk("ack_wait", 32'h2, i);
    q = wb_dat;
    req <= '0;
    @(posedge mclk_i);
  endtask
  task automatic set(input logic [9:0] c);
    wb(1'b1, 4'h0, {22'h0, c});
  endtask
  task automatic push(input logic [2:0] w);
    // word stable from just after a rising edge
    lw <= w;
    lv <= 1'b1;
    @(posedge mclk_i);
    lv <= 1'b0;
    repeat (5) @(posedge mclk_i);
  endtask
  task automatic t_reg;
    wb(1'b0, 4'h0, 32'h0);
    chk("ctrl_rst", 32'h0, q);
    set(10'h0c6);
    wb(1'b0, 4'h0, 32'h0);
    chk("ctrl", 32'h0c6, q);
    wb(1'b1, 4'h8, 32'hffff_ffff);
    wb(1'b0, 4'h8, 32'h0);
    chk("unmapped", 32'h0, q);
    set(10'h000);
    $display("t_reg done");
  endtask
  task automatic t_unreg;
    for (int v = 0; v < 2; v++) begin
      rv <= v[0];
      fv <= v[0];
      repeat (3) @(posedge mclk_i);
      chk("cap0", v, {31'h0, cap[0]});
      chk("bypass", v, {31'h0, byp});
      chk("oe_off", 32'h0, {31'h0, pad_oe});
    end
    $display("t_unreg done");
  endtask
  task automatic t_sdr;
    set(10'h046);
    push(3'b101);
    chk("pad_inv", 32'h0, {31'h0, pad_o});
    chk("oe_on", 32'h1, {31'h0, pad_oe});
    chk("cap_own", 32'h0, {31'h0, cap[0]});
    set(10'h006);
    push(3'b001);
    chk("pad", 32'h1, {31'h0, pad_o});
    chk("oe_drop", 32'h0, {31'h0, pad_oe});
    set(10'h036);
    lw <= 3'b100;
    lv <= 1'b1;
    @(posedge mclk_i);
    lv <= 1'b0;
    @(posedge mclk_i);
    @(negedge mclk_i);
    #2 chk("pad_neg", 32'h0, {31'h0, pad_o});
    chk("oe_neg", 32'h1, {31'h0, pad_oe});
    @(posedge mclk_i);
    push(3'b001);
    $display("t_sdr done");
  endtask
  task automatic t_inreg;
    set(10'h001);
    rv <= 1'b1;
    fv <= 1'b1;
    repeat (3) @(posedge mclk_i);
    chk("cap_reg", 32'h1, {31'h0, cap[0]});
    chk("bypass_off", 32'h0, {31'h0, byp});
    set(10'h009);
    rv <= 1'b1;
    fv <= 1'b0;
    repeat (3) @(posedge mclk_i);
    chk("cap_neg", 32'h0, {31'h0, cap[0]});
    $display("t_inreg done");
  endtask
  task automatic t_dual;
    set(10'h084);
    push(3'b110);
    @(posedge mclk_i);
    #6 chk("pad_hi", 32'h0, {31'h0, pad_o});
    @(negedge mclk_i);
    #6 chk("pad_lo", 32'h1, {31'h0, pad_o});
    @(posedge mclk_i);
    push(3'b000);
    set(10'h080);
    rv <= 1'b1;
    fv <= 1'b0;
    repeat (3) @(posedge mclk_i);
    #2 chk("cap_rise", 32'h1, {31'h0, cap[0]});
    @(negedge mclk_i);
    #2 chk("cap_fall", 32'h0, {31'h0, cap[1]});
    @(posedge mclk_i);
    set(10'h180);
    rv <= 1'b0;
    fv <= 1'b1;
    repeat (3) @(posedge mclk_i);
    #2 chk("cap_resync", 32'h2, {30'h0, cap});
    @(posedge mclk_i);
    $display("t_dual done");
  endtask
  task automatic t_fifo;
    set(10'h200);
    n = 0;
    lw <= 3'b001;
    lv <= 1'b1;
    repeat (8) begin
      @(posedge mclk_i);
      if (lr === 1'b1)
        n++;
    end
    lv <= 1'b0;
    chk("fill", 32'h4, n);
    wb(1'b0, 4'h4, 32'h0);
    chk("level_full", 32'h4, {29'h0, q[8:6]});
    set(10'h000);
    repeat (8) @(posedge mclk_i);
    wb(1'b0, 4'h4, 32'h0);
    chk("level_empty", 32'h0, {29'h0, q[8:6]});
    $display("t_fifo done");
  endtask
  // Free-running clock
  initial begin
    mclk_i = 1'b0;
    forever #12.5 mclk_i = ~mclk_i;
  end
  // Hang guard
  initial begin
    #125000;
    fail_count++;
    finish_test;
  end
  // Main sequence
  initial begin
    rst_n_i = 1'b0;
    req = '0;
    lw = '0;
    lv = 1'b0;
    rv = 1'b1;
    fv = 1'b1;
    repeat (8) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    t_reg;
    t_unreg;
    t_sdr;
    t_inreg;
    t_dual;
    t_fifo;
    finish_test;
  end
endmodule
